// >>> hw/spi_pin_sampler.sv
// Synchronises the serial pins and finds clock and select edges
`timescale 1ns/1ps
module spi_pin_sampler
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic select_low_pin_i,
  input wire logic serial_clk_i,
  input wire logic serial_in_i,
  spi_shift_if.sampler bus
);
  logic [1:0] sel_sync;
  logic [1:0] clk_sync;
  logic [1:0] din_sync;
  logic sel_prev;
  logic clk_prev;
  wire sel_low = ~sel_sync[1];
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sel_sync <= 2'h3;
      clk_sync <= 2'h0;
      din_sync <= 2'h0;
      sel_prev <= 1'b1;
      clk_prev <= 1'b0;
    end
    else
    begin
      sel_sync <= {sel_sync[0], select_low_pin_i};
      clk_sync <= {clk_sync[0], serial_clk_i};
      din_sync <= {din_sync[0], serial_in_i};
      sel_prev <= sel_sync[1];
      clk_prev <= clk_sync[1];
    end
  end
  assign bus.active = sel_low;
  assign bus.rise = sel_low & clk_sync[1] & ~clk_prev;
  assign bus.fall = sel_low & ~clk_sync[1] & clk_prev;
  assign bus.data_in = din_sync[1];
  assign bus.start = sel_prev & ~sel_sync[1];
  assign bus.stop = ~sel_prev & sel_sync[1];
endmodule

// >>> hw/spi_shift_if.sv
// Bit-level events passed from the pin sampler to the transaction logic
`timescale 1ns/1ps
interface spi_shift_if;
  logic active;
  logic rise;
  logic fall;
  logic data_in;
  logic start;
  logic stop;
  modport sampler (output active, output rise, output fall, output data_in, output start,
    output stop);
  modport engine (input active, input rise, input fall, input data_in, input start,
    input stop);
endinterface

// >>> hw/spi_status_access.sv
// Serial slave front end: status byte, configuration and status register access
`timescale 1ns/1ps
`include "spi_status_defs.svh"
module spi_status_access
  import spi_status_pkg::*;
#(
  parameter int CFG_COUNT = 48,
  parameter int STATUS_COUNT = 14
)
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic select_low_pin_i,
  input wire logic serial_clk_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_en_o,
  input wire logic osc_stable_i,
  input wire logic supply_stable_i,
  input wire logic [2:0] radio_state_i,
  input wire logic transitional_i,
  input wire logic [6:0] rx_bytes_i,
  input wire logic [6:0] tx_free_i,
  input wire logic [8*STATUS_COUNT-1:0] status_regs_i,
  output logic [8*CFG_COUNT-1:0] config_o,
  output logic [5:0] strobe_addr_o,
  output logic strobe_o,
  output logic ready_low_flag_o,
  output logic idle_power_o
);
  // Six header address bits and the strobe range cap both register counts
  if (CFG_COUNT < 1 || CFG_COUNT > 48 || STATUS_COUNT < 1 || STATUS_COUNT > 14)
  begin : g_bad_counts
    $error("Register counts out of range");
  end

  spi_shift_if pins ();
  spi_pin_sampler sampler
  (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .select_low_pin_i(select_low_pin_i),
    .serial_clk_i(serial_clk_i),
    .serial_in_i(serial_in_i),
    .bus(pins)
  );

  logic [7:0] cfg_mem [CFG_COUNT];
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [2:0] bit_cnt;
  logic [5:0] addr;
  logic is_read;
  logic is_burst;
  spi_phase_t phase;
  logic [1:0] osc_sync;
  logic [1:0] vdd_sync;

  // Both stability inputs come from analog monitors outside this clock
  wire ready = osc_sync[1] & vdd_sync[1];
  wire [7:0] rx_in = {shift_in[6:0], pins.data_in};
  wire byte_done = pins.rise & (bit_cnt == 3'h7);
  wire hdr_read = rx_in[`HDR_RW_BIT];
  wire hdr_burst = rx_in[`HDR_BURST_BIT];
  wire [5:0] hdr_addr = rx_in[5:0];
  wire in_strobe = (hdr_addr >= `STROBE_FIRST_ADDR) && (hdr_addr <= `STROBE_LAST_ADDR);
  wire hdr_status_rd = in_strobe & hdr_burst;
  wire hdr_strobe = in_strobe & ~hdr_burst;
  wire hdr_cfg = hdr_addr < 6'(CFG_COUNT);
  // A header's own direction bit is not in yet when its status byte is loaded,
  // so at select fall the level on the data pin stands in for it
  wire count_read = pins.start ? pins.data_in : (phase == phase_data) ? is_read : hdr_read;
  wire [6:0] count_src = count_read ? rx_bytes_i : tx_free_i;
  wire [3:0] count_sat = (count_src > 7'(`COUNT_MAX)) ? `COUNT_MAX : count_src[3:0];
  wire [2:0] state_rep = transitional_i ? 3'(idle_state) : radio_state_i;
  wire [7:0] status_byte = {~ready, state_rep, count_sat};
  wire [3:0] stat_idx = 4'(hdr_addr - `STROBE_FIRST_ADDR);
  wire [7:0] stat_val = (stat_idx < 4'(STATUS_COUNT)) ? status_regs_i[8*stat_idx +: 8] :
    `STATUS_REG_RESET;
  wire [7:0] hdr_read_val = hdr_status_rd ? stat_val :
    hdr_cfg ? cfg_mem[hdr_addr] : `CFG_RESET_VALUE;
  wire [5:0] next_addr = addr + 6'h01;
  wire burst_cfg = is_burst & (next_addr < 6'(CFG_COUNT));
  wire [7:0] burst_read_val = burst_cfg ? cfg_mem[next_addr] : `CFG_RESET_VALUE;
  wire data_write = (phase == phase_data) & byte_done & ~is_read & (addr < 6'(CFG_COUNT));
  // Only a header can strobe; data bytes that look like strobe addresses must not
  wire strobe_fire = (phase == phase_header) & byte_done & hdr_strobe;

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      osc_sync <= 2'h0;
      vdd_sync <= 2'h0;
    end
    else
    begin
      osc_sync <= {osc_sync[0], osc_stable_i};
      vdd_sync <= {vdd_sync[0], supply_stable_i};
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      shift_in <= 8'h00;
      bit_cnt <= 3'h0;
    end
    else if (!pins.active)
    begin
      bit_cnt <= 3'h0;
    end
    else if (pins.rise)
    begin
      shift_in <= rx_in;
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // Transaction sequencing; select high always returns to a fresh header
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      phase <= phase_header;
      addr <= 6'h00;
      is_read <= 1'b0;
      is_burst <= 1'b0;
    end
    else if (!pins.active)
    begin
      phase <= phase_header;
    end
    else if (byte_done)
    begin
      case (phase)
        phase_header:
        begin
          addr <= hdr_addr;
          is_read <= hdr_read;
          is_burst <= hdr_burst & ~hdr_status_rd;
          phase <= hdr_strobe ? phase_header : phase_data;
        end
        phase_data:
        begin
          if (is_burst)
          begin
            addr <= next_addr;
          end
          else
          begin
            phase <= phase_header;
          end
        end
        phase_discard:
          phase <= phase_header;
        default:
          phase <= phase_header;
      endcase
    end
  end

  generate
    for (genvar i = 0; i < CFG_COUNT; i++)
    begin : g_cfg
      always_ff @(posedge ref_clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
          cfg_mem[i] <= `CFG_RESET_VALUE;
        else if (data_write && addr == 6'(i))
          cfg_mem[i] <= rx_in;
      end
      assign config_o[8*i +: 8] = cfg_mem[i];
    end
  endgenerate

  // Output byte is loaded before the first bit and shifted on the falling edges after a byte's first seven rising edges
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      shift_out <= 8'hFF;
    end
    else if (pins.start)
    begin
      shift_out <= status_byte;
    end
    else if (byte_done)
    begin
      if (phase == phase_header && hdr_read && !hdr_strobe)
        shift_out <= hdr_read_val;
      else if (phase == phase_data && is_read && is_burst)
        shift_out <= burst_read_val;
      else
        shift_out <= status_byte;
    end
    else if (pins.fall && bit_cnt != 3'h0)
    begin
      shift_out <= {shift_out[6:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      serial_out_o <= 1'b1;
      serial_out_en_o <= 1'b0;
      strobe_o <= 1'b0;
      strobe_addr_o <= 6'h00;
      ready_low_flag_o <= 1'b1;
      idle_power_o <= 1'b1;
    end
    else
    begin
      // Before the first bit the pin shows the ready flag so the master can poll it
      serial_out_o <= shift_out[7];
      serial_out_en_o <= pins.active;
      strobe_o <= strobe_fire;
      strobe_addr_o <= strobe_fire ? hdr_addr : strobe_addr_o;
      ready_low_flag_o <= ~ready;
      idle_power_o <= (radio_state_i == 3'(idle_state));
    end
  end
endmodule

// >>> hw/spi_status_defs.svh
// Constants for the serial status and register access front end
`ifndef SPI_STATUS_DEFS_SVH
`define SPI_STATUS_DEFS_SVH
`define HDR_RW_BIT 7
`define HDR_BURST_BIT 6
`define STAT_READY_BIT 7
`define STAT_STATE_MSB 6
`define STAT_STATE_LSB 4
`define COUNT_MAX 4'hF
`define CFG_LAST_ADDR 6'h2F
`define STROBE_FIRST_ADDR 6'h30
`define STROBE_LAST_ADDR 6'h3D
`define CFG_RESET_VALUE 8'h00
`define STATUS_REG_RESET 8'h00
`endif

// >>> hw/spi_status_pkg.sv
// Types shared by the serial status front end
package spi_status_pkg;
  typedef enum logic [2:0] {
    idle_state = 3'b000,
    receive_state = 3'b001,
    transmit_state = 3'b010,
    synth_on_state = 3'b011,
    calibrate_state = 3'b100,
    settling_state = 3'b101,
    receive_queue_overrun_state = 3'b110,
    transmit_queue_underrun_state = 3'b111
  } radio_state_t;
  typedef enum {
    phase_header,
    phase_data,
    phase_discard
  } spi_phase_t;
endpackage

// >>> tb/spi_master_model.sv
// Serial master model framing bytes toward the device
`timescale 1ns/1ps
module spi_master_model
(
  input wire logic ref_clk_i,
  input wire logic serial_out_i,
  output logic select_low_pin_o,
  output logic serial_clk_o,
  output logic serial_in_o
);
  initial
  begin
    select_low_pin_o = 1'h1;
    serial_clk_o = 1'h0;
    serial_in_o = 1'h1;
  end
  // Data line takes the r/w bit in the same step as select falls; clock stands low
  task automatic sel(input logic hi, input logic rw);
    @(negedge ref_clk_i);
    serial_in_o = rw;
    select_low_pin_o = hi;
    repeat (8) @(negedge ref_clk_i);
    for (int i = 0; i < 99 && !hi && serial_out_i !== 1'h0; i++)
      @(negedge ref_clk_i);
  endtask
  // Sampled mid high phase, as the output lags each clock edge
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      serial_in_o = tx[i];
      #16 serial_clk_o = 1'h1;
      #8 rx[i] = serial_out_i;
      #8 serial_clk_o = 1'h0;
    end
  endtask
endmodule

// >>> tb/spi_status_sva.sv
// Port assertions for the status front end
`timescale 1ns/1ps
module spi_status_sva #(parameter int CFG_COUNT = 48)
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic select_low_pin_i,
  input wire logic osc_stable_i,
  input wire logic supply_stable_i,
  input wire logic [2:0] radio_state_i,
  input wire logic serial_out_en_o,
  input wire logic [8*CFG_COUNT-1:0] config_o,
  input wire logic [5:0] strobe_addr_o,
  input wire logic strobe_o,
  input wire logic ready_low_flag_o,
  input wire logic idle_power_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  rdy_high_a: assert property ((!osc_stable_i) [*5] |-> ready_low_flag_o)
    else $error("ready without oscillator");
  rdy_low_a: assert property ((osc_stable_i && supply_stable_i) [*6] |-> !ready_low_flag_o)
    else $error("ready flag stuck");
  idle_pwr_a: assert property ((radio_state_i == 3'h0) [*3] |-> idle_power_o)
    else $error("idle power off");
  en_on_a: assert property ((!select_low_pin_i) [*5] |-> serial_out_en_o)
    else $error("output not driven");
  en_off_a: assert property (select_low_pin_i [*5] |-> !serial_out_en_o)
    else $error("output driven while idle");
  stb_pulse_a: assert property (strobe_o |=> !strobe_o)
    else $error("strobe too long");
  stb_addr_a: assert property (strobe_o |=> strobe_addr_o inside {[6'h30:6'h3D]})
    else $error("strobe address off");
  cfg_hold_a: assert property (select_low_pin_i [*5] |-> $stable(config_o))
    else $error("config moved");
  cover property (strobe_o);
  cover property ($fell(ready_low_flag_o));
  cover property ($changed(config_o));
endmodule
bind spi_status_access spi_status_sva #(.CFG_COUNT(CFG_COUNT)) i_sva
(
  .ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i),
  .select_low_pin_i(select_low_pin_i),
  .osc_stable_i(osc_stable_i),
  .supply_stable_i(supply_stable_i),
  .radio_state_i(radio_state_i),
  .serial_out_en_o(serial_out_en_o),
  .config_o(config_o),
  .strobe_addr_o(strobe_addr_o),
  .strobe_o(strobe_o),
  .ready_low_flag_o(ready_low_flag_o),
  .idle_power_o(idle_power_o)
);

// >>> tb/testbench.sv
// Bench for the status front end
`timescale 1ns/1ps
module testbench;
  logic ref_clk_i = 1'h0, reset_n_i = 1'h0, osc_stable_i = 1'h0, supply_stable_i = 1'h0;
  logic transitional_i = 1'h0;
  logic [2:0] radio_state_i = 3'h0;
  logic [6:0] rx_bytes_i = 7'h14, tx_free_i = 7'h03;
  logic [111:0] status_regs_i = {14{8'h93}};
  logic select_low_pin_i, serial_clk_i, serial_in_i, serial_out_o, serial_out_en_o;
  logic strobe_o, ready_low_flag_o, idle_power_o;
  logic [5:0] strobe_addr_o;
  logic [383:0] config_o;
  logic [7:0] rd;
  int n_mismatch = 0;
  int checked = 0;
  int n_strobe = 0;
  // Counted at the falling edge, clear of the edge that launches the pulse
  always @(negedge ref_clk_i)
    if (strobe_o)
      n_strobe++;
  spi_status_access i_dut (.*);
  spi_master_model i_master (.ref_clk_i, .serial_out_i(serial_out_o),
    .select_low_pin_o(select_low_pin_i), .serial_clk_o(serial_clk_i), .serial_in_o(serial_in_i));
  initial forever #2 ref_clk_i = ~ref_clk_i;
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h not %h", $time, seen, want);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic frame(input logic [7:0] tx[$], input logic [7:0] want[$]);
    i_master.sel(1'h0, tx[0][7]);
    check(8'(serial_out_en_o), 8'h01);
    foreach (tx[i])
    begin
      i_master.xfer(tx[i], 8, rd);
      check(rd, want[i]);
    end
    i_master.sel(1'h1, 1'h1);
    check(8'(serial_out_en_o), 8'h00);
  endtask
  task automatic t_ready;
    osc_stable_i = 1'h1;
    repeat (8) @(negedge ref_clk_i);
    check(8'(ready_low_flag_o), 8'h01);
    supply_stable_i = 1'h1;
    repeat (8) @(negedge ref_clk_i);
    check(8'(ready_low_flag_o), 8'h00);
    $display("test ready done");
  endtask
  task automatic t_states;
    for (int k = 0; k < 8; k++)
    begin
      radio_state_i = 3'(k);
      tx_free_i = 7'(9 * k);
      frame('{8'h30 + 8'(k)}, '{{1'h0, 3'(k), k < 2 ? 4'(9 * k) : 4'hF}});
      check(8'(strobe_addr_o), 8'h30 + 8'(k));
      check(8'(n_strobe), 8'(k + 1));
      check(8'(idle_power_o), 8'(k == 0));
    end
    radio_state_i = 3'h5;
    transitional_i = 1'h1;
    frame('{8'h3D}, '{8'h0F});
    check(8'(n_strobe), 8'h09);
    transitional_i = 1'h0;
    radio_state_i = 3'h0; // Settings change only while idle
    tx_free_i = 7'h03;
    $display("test states done");
  endtask
  task automatic t_config;
    frame('{8'h6E, 8'h25, 8'h5A}, '{8'h03, 8'h03, 8'h03});
    check(config_o[375:368], 8'h25);
    check(config_o[383:376], 8'h5A);
    frame('{8'hEE, 8'hFF, 8'hFF}, '{8'h0F, 8'h25, 8'h5A});
    frame('{8'hF3, 8'hFF}, '{8'h0F, 8'h5C});
    check(8'(strobe_addr_o), 8'h3D);
    check(8'(n_strobe), 8'h09);
    $display("test config done");
  endtask
  task automatic t_abort;
    i_master.sel(1'h0, 1'h0);
    i_master.xfer(8'h05, 8, rd);
    i_master.xfer(8'h7E, 4, rd);
    i_master.sel(1'h1, 1'h1);
    check(config_o[47:40], 8'h00);
    frame('{8'h05, 8'h3C}, '{8'h03, 8'h03});
    check(config_o[47:40], 8'h3C);
    check(8'(strobe_addr_o), 8'h3D);
    check(8'(n_strobe), 8'h09);
    $display("test abort done");
  endtask
  initial
  begin
    status_regs_i[31:24] = 8'h5C;
    repeat (12) @(negedge ref_clk_i);
    check({serial_out_o, serial_out_en_o, strobe_o, ready_low_flag_o, idle_power_o, 3'h0},
      8'h98);
    reset_n_i = 1'h1;
    t_ready;
    t_states;
    t_config;
    t_abort;
    complete_run;
  end
  initial
  begin
    #200000;
    n_mismatch++;
    complete_run;
  end
endmodule
